//--- bench/rcso_user_model.sv
`timescale 1ns/100ps
// User logic that takes completion beats and records them for the bench.
module rcso_user_model
    import rcso_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic hold,
    input wire logic [255:0] data,
    input wire logic [7:0] keep,
    input wire logic last,
    input wire logic valid,
    output logic ready_ff,
    input wire logic [SB_W-1:0] sideband,
    output logic [7:0] beat_cnt_ff
);
    // ----------------------------------------------------------------
    // Capture store.
    // ----------------------------------------------------------------
    logic [42:0] cap[16]; // Discontinue, start, last, keep and strobes of each beat.
    logic [255:0] cap_data[16]; // Data of each beat.
    logic [8:0] cap_flag[16]; // Second start and both end groups of each beat.
    logic drop_ff; // Packet marked for discard.

    // Ready may drop in any cycle; slow toggles it, hold parks it low.
    // Second flags are only recorded for the bench, never acted on.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ready_ff <= 1'b0;
            beat_cnt_ff <= 8'h00;
            drop_ff <= 1'b0;
        end else begin
            ready_ff <= !hold && (!slow || !ready_ff);
            if (valid && ready_ff) begin
                cap[beat_cnt_ff[3:0]] <= {sideband[SB_DISC], sideband[SB_SOF0], last, keep,
                    sideband[31:0]};
                cap_data[beat_cnt_ff[3:0]] <= data;
                cap_flag[beat_cnt_ff[3:0]] <= sideband[SB_EOF1_LSB+3:SB_SOF1];
                beat_cnt_ff <= beat_cnt_ff + 8'h01;
                drop_ff <= last && sideband[SB_DISC];
            end
        end
    end
endmodule : rcso_user_model

//--- bench/tb_requester_completion_stream_out.sv
`timescale 1ns/100ps
module tb_requester_completion_stream_out
    import rcso_pkg::*;
    ;
    // ----------------------------------------------------------------
    // Stimulus and observation signals.
    // ----------------------------------------------------------------
    logic ref_clk = 1'b0; // User clock, 40 MHz.
    logic resetn; // Asynchronous reset, active low.
    logic src_valid, src_ready, src_sop, src_eop, src_discontinue, src_addr_aligned;
    logic [31:0] src_dword;
    logic [3:0] src_byte_en;
    logic [2:0] src_addr_offset;
    logic [255:0] out_data;
    logic [7:0] out_keep;
    logic out_last, out_valid, out_ready, slow, hold;
    logic [SB_W-1:0] sideband;
    logic [7:0] beat_cnt;
    logic gated_valid, both_ready, str_src_ready, str_last, str_valid, str_ready;
    logic [255:0] str_data;
    logic [7:0] str_keep, str_cnt;
    logic [SB_W-1:0] str_sb;
    int error_cnt = 0;
    int checked = 0;
    int refused = 0; // Source cycles held off by a full buffer.

    always #12.5 ref_clk = ~ref_clk;

    rcso_framer #(.LANES(8), .straddle_enable_param(1'b0), .FIFO_DEPTH(8)) i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .src_valid(gated_valid), .src_ready(src_ready),
        .src_dword(src_dword), .src_byte_en(src_byte_en), .src_sop(src_sop),
        .src_eop(src_eop), .src_discontinue(src_discontinue),
        .src_addr_aligned(src_addr_aligned), .src_addr_offset(src_addr_offset),
        .completion_out_data(out_data), .completion_out_keep(out_keep),
        .completion_out_last(out_last), .completion_out_valid(out_valid),
        .completion_out_ready(out_ready), .completion_sideband(sideband));

    rcso_user_model i_user (
        .ref_clk(ref_clk), .resetn(resetn), .slow(slow), .hold(hold), .data(out_data),
        .keep(out_keep), .last(out_last), .valid(out_valid), .ready_ff(out_ready),
        .sideband(sideband), .beat_cnt_ff(beat_cnt));

    // Both builds take each Dword together, so one source feeds both.
    assign both_ready = src_ready && str_src_ready;
    assign gated_valid = src_valid && both_ready;

    // Straddled build on the same source, watched through its own user model.
    rcso_framer #(.LANES(8), .straddle_enable_param(1'b1), .FIFO_DEPTH(8)) i_dut_str (
        .ref_clk(ref_clk), .resetn(resetn), .src_valid(gated_valid), .src_ready(str_src_ready),
        .src_dword(src_dword), .src_byte_en(src_byte_en), .src_sop(src_sop),
        .src_eop(src_eop), .src_discontinue(src_discontinue),
        .src_addr_aligned(src_addr_aligned), .src_addr_offset(src_addr_offset),
        .completion_out_data(str_data), .completion_out_keep(str_keep),
        .completion_out_last(str_last), .completion_out_valid(str_valid),
        .completion_out_ready(str_ready), .completion_sideband(str_sb));

    rcso_user_model i_user_str (
        .ref_clk(ref_clk), .resetn(resetn), .slow(slow), .hold(hold), .data(str_data),
        .keep(str_keep), .last(str_last), .valid(str_valid), .ready_ff(str_ready),
        .sideband(str_sb), .beat_cnt_ff(str_cnt));

    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    // Prints the counts and the verdict, then stops the run.
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // Compares one value; case inequality so an unknown never matches.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Sends one completion: three descriptor Dwords, then the payload.
    // Valid stays high at the end; the caller drops it, so packets may run back to back.
    task automatic send_pkt(input logic aa, input logic [2:0] off, input int npay,
        input logic [3:0] be, input logic disc);
        int i;
        int n;
        for (i = 0; i < 3 + npay; i++) begin
            src_valid <= 1'b1;
            src_dword <= (i < 3) ? 32'hD000_0000 + i : 32'hA000_0000 + i - 3;
            src_byte_en <= (i < 3) ? 4'h0 : be;
            src_sop <= (i == 0);
            src_eop <= (i == 2 + npay);
            src_discontinue <= disc && (i == 2 + npay);
            src_addr_aligned <= aa;
            src_addr_offset <= off;
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
                if (both_ready !== 1'b1) refused++;
            end while (both_ready !== 1'b1 && n < 200);
            if (n >= 200) begin
                error_cnt++;
                finish_test;
            end
        end
    endtask : send_pkt

    // Waits, bounded, until the user side has taken the given number of beats.
    task automatic wait_beats(input int target);
        int n;
        n = 0;
        while (beat_cnt < target && n < 500) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 500) begin
            error_cnt++;
            finish_test;
        end
    endtask : wait_beats

    // ----------------------------------------------------------------
    // Main sequence; beat fields are {disc, start, last, keep, strobes}.
    // ----------------------------------------------------------------
    initial begin
        resetn <= 1'b0;
        {src_valid, src_sop, src_eop, src_discontinue, src_addr_aligned} <= 5'h00;
        src_dword <= 32'h0000_0000;
        src_byte_en <= 4'h0;
        src_addr_offset <= 3'h0;
        slow <= 1'b0;
        hold <= 1'b0;
        repeat (16) @(posedge ref_clk);
        check(64'(out_valid), 64'h0);
        resetn <= 1'b1;
        @(posedge ref_clk);
        // One payload Dword with only its two middle byte strobes set.
        send_pkt(1'b0, 3'h0, 1, 4'h6, 1'b0);
        src_valid <= 1'b0;
        wait_beats(1);
        check(64'(i_user.cap[0]), 64'({3'b011, 8'h0F, 32'h0000_6000}));
        check(64'(i_user.cap_data[0][127:96]), 64'h0000_0000_A000_0000);
        // Zero-length read: one dummy Dword, all strobes clear.
        send_pkt(1'b0, 3'h0, 1, 4'h0, 1'b0);
        src_valid <= 1'b0;
        wait_beats(2);
        check(64'(i_user.cap[1]), 64'({3'b011, 8'h0F, 32'h0000_0000}));
        // Two packets against a stalled user side; the buffer must refuse.
        hold <= 1'b1;
        fork
            begin
                send_pkt(1'b0, 3'h0, 9, 4'hF, 1'b1);
                send_pkt(1'b1, 3'h5, 10, 4'hF, 1'b0);
                src_valid <= 1'b0;
            end
            begin
                repeat (80) @(posedge ref_clk);
                hold <= 1'b0;
                slow <= 1'b1;
            end
        join
        wait_beats(7);
        check(64'(refused > 0), 64'h1);
        check(64'(i_user.cap[2]), 64'({3'b010, 8'hFF, 32'hFFFF_F000}));
        check(64'(i_user.cap[3]), 64'({3'b101, 8'h0F, 32'h0000_FFFF}));
        check(64'(i_user.cap_data[3][127:96]), 64'h0000_0000_A000_0008);
        check(64'(i_user.cap[4]), 64'({3'b010, 8'hFF, 32'h0000_0000}));
        check(64'(i_user.cap[5]), 64'({3'b000, 8'hFF, 32'hFFF0_0000}));
        check(64'(i_user.cap_data[5][191:160]), 64'h0000_0000_A000_0000);
        check(64'(i_user.cap[6]), 64'({3'b001, 8'h7F, 32'h0FFF_FFFF}));
        repeat (20) @(posedge ref_clk);
        check(64'(beat_cnt), 64'h7);
        // Two short packets back to back: the straddled build shares one beat.
        send_pkt(1'b0, 3'h0, 1, 4'hF, 1'b0);
        send_pkt(1'b0, 3'h0, 1, 4'h3, 1'b0);
        src_valid <= 1'b0;
        wait_beats(9);
        check(64'(i_user.cap[7]), 64'({3'b011, 8'h0F, 32'h0000_F000}));
        check(64'(i_user.cap[8]), 64'({3'b011, 8'h0F, 32'h0000_3000}));
        repeat (20) @(posedge ref_clk);
        check(64'(beat_cnt), 64'h9);
        check(64'(str_cnt), 64'h7);
        check(64'(i_user_str.cap[0]), 64'({3'b010, 8'hFF, 32'h0000_6000}));
        check(64'(i_user_str.cap_flag[0]), 64'h00E);
        check(64'(i_user_str.cap[3]), 64'({3'b100, 8'hFF, 32'h0000_FFFF}));
        check(64'(i_user_str.cap_flag[3]), 64'h00E);
        check(64'(i_user_str.cap[4]), 64'({3'b010, 8'hFF, 32'hFFFF_F000}));
        check(64'(i_user_str.cap_flag[5]), 64'h012);
        check(64'(i_user_str.cap[6]), 64'({3'b010, 8'hFF, 32'h3000_F000}));
        check(64'(i_user_str.cap_flag[6]), 64'h1EF);
        finish_test;
    end
endmodule : tb_requester_completion_stream_out

//--- core/rcso_fifo.sv
`timescale 1ns/100ps
module rcso_fifo
#(
    parameter int unsigned WIDTH = 43,
    parameter int unsigned DEPTH = 8
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    rcso_stream_if.sink wr,
    rcso_stream_if.source rd
);
    import rcso_pkg::*;

    // ------------------------------------------------------------
    // Storage and pointers.
    // ------------------------------------------------------------
    localparam int unsigned AW = $clog2(DEPTH);

    // Pointers carry one extra wrap bit so full and empty differ.
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("rcso_fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];   // Word storage.
    logic [AW:0] wptr_ff;            // Write pointer.
    logic [AW:0] rptr_ff;            // Read pointer.
    logic [AW:0] nxt_wptr;
    logic [AW:0] nxt_rptr;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wptr_ff == rptr_ff);
    assign full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rptr_ff[AW-1:0]];
    assign push = wr.valid && !full;
    assign pop = rd.ready && !empty;

    // Pointer advance on each accepted push and pop.
    always_comb begin
        nxt_wptr = push ? wptr_ff + 1'b1 : wptr_ff;
        nxt_rptr = pop ? rptr_ff + 1'b1 : rptr_ff;
    end

    // Pointers reset to empty; the array needs no reset.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
        end else begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
        end
    end

    // Words land at the write pointer.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wptr_ff[AW-1:0]] <= wr.data;
        end
    end

endmodule : rcso_fifo

//--- core/rcso_framer.sv
`timescale 1ns/100ps
module rcso_framer
    import rcso_pkg::*;
#(
    parameter int unsigned LANES = 8,                  // Dwords per beat: 2, 4 or 8.
    parameter bit straddle_enable_param = 1'b0,        // Straddle option.
    parameter int unsigned FIFO_DEPTH = 8              // Buffered Dwords.
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic src_valid,
    output logic src_ready,
    input wire logic [31:0] src_dword,
    input wire logic [3:0] src_byte_en,
    input wire logic src_sop,
    input wire logic src_eop,
    input wire logic src_discontinue,
    input wire logic src_addr_aligned,
    input wire logic [2:0] src_addr_offset,
    output logic [32*LANES-1:0] completion_out_data,
    output logic [LANES-1:0] completion_out_keep,
    output logic completion_out_last,
    output logic completion_out_valid,
    input wire logic completion_out_ready,
    output logic [SB_W-1:0] completion_sideband
);

    // ------------------------------------------------------------
    // Configuration checks.
    // ------------------------------------------------------------
    if (LANES != 2 && LANES != 4 && LANES != 8) begin : g_bad_lanes
        $error("rcso_framer lanes must be 2, 4 or 8");
    end
    if (straddle_enable_param && LANES != 8) begin : g_bad_straddle
        $error("rcso_framer straddle needs eight lanes");
    end

    localparam int unsigned DW_W = 32 * LANES;
    localparam int unsigned BE_W = 4 * LANES;
    localparam logic [2:0] LAST_LANE = 3'(LANES - 1);
    localparam bit STR = straddle_enable_param;

    // Ones on every lane up to and including the given one.
    function automatic logic [LANES-1:0] fill_mask(input logic [2:0] last);
        logic [LANES-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i] = (3'(i) <= last);
        end
        return m;
    endfunction : fill_mask

    // ------------------------------------------------------------
    // Input buffer.
    // ------------------------------------------------------------
    rcso_stream_if #(.W(ENT_W)) in_if ();
    rcso_stream_if #(.W(ENT_W)) buf_if ();

    assign in_if.valid = src_valid;
    assign in_if.data = {src_addr_offset, src_addr_aligned, src_discontinue,
                         src_eop, src_sop, src_byte_en, src_dword};
    // The buffer's ready is the source's back-pressure.
    assign src_ready = in_if.ready;

    rcso_fifo #(.WIDTH(ENT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .wr(in_if),
        .rd(buf_if)
    );

    // Fields of the Dword at the buffer head.
    logic [31:0] e_dw;
    logic [3:0] e_be;
    logic e_sop;
    logic e_eop;
    logic e_disc;
    logic e_aa;
    logic [2:0] e_off;
    assign e_dw = buf_if.data[ENT_DW_LSB +: 32];
    assign e_be = buf_if.data[ENT_BE_LSB +: 4];
    assign e_sop = buf_if.data[ENT_SOP];
    assign e_eop = buf_if.data[ENT_EOP];
    assign e_disc = buf_if.data[ENT_DISC];
    // Straddled builds never place by address.
    assign e_aa = buf_if.data[ENT_AA] && !STR;
    assign e_off = buf_if.data[ENT_OFF_LSB +: 3];

    // ------------------------------------------------------------
    // Beat gatherer and output stage state.
    // ------------------------------------------------------------
    rcso_state_t st_ff, nxt_st;          // Packet progress.
    logic [1:0] dcnt_ff, nxt_dcnt;       // Descriptor Dwords seen.
    logic [2:0] pos_ff, nxt_pos;         // Next free Dword lane.
    logic [DW_W-1:0] acc_data_ff, nxt_acc_data;  // Beat being gathered.
    logic [BE_W-1:0] acc_be_ff, nxt_acc_be;      // Its byte strobes.
    logic [1:0] starts_ff, nxt_starts;   // Packets started in this beat.
    logic [1:0] ends_ff, nxt_ends;       // Packets ended in this beat.
    logic [2:0] eof0_ff, nxt_eof0;       // Lane of the first end.
    logic [2:0] eof1_ff, nxt_eof1;       // Lane of the second end.
    logic disc_ff, nxt_disc;             // Discontinue for this beat.
    logic [DW_W-1:0] nxt_out_data;
    logic [LANES-1:0] nxt_out_keep;
    logic nxt_out_last;
    logic nxt_out_valid;
    logic [SB_W-1:0] nxt_sb;
    logic can_out;                       // Output stage free this cycle.
    logic take;                          // Head Dword consumed.
    logic flush;                         // Gathered beat moves to output.
    logic pkt_end;                       // A packet closes this beat.
    logic desc_done;                     // Descriptor completes now.

    assign can_out = !completion_out_valid || completion_out_ready;
    assign buf_if.ready = take;

    // Gathering proceeds only while the output stage can take a beat,
    // which keeps the flush decision a single cycle at the cost of a
    // bubble when the user stalls.
    always_comb begin
        nxt_st = st_ff;
        nxt_dcnt = dcnt_ff;
        nxt_pos = pos_ff;
        nxt_acc_data = acc_data_ff;
        nxt_acc_be = acc_be_ff;
        nxt_starts = starts_ff;
        nxt_ends = ends_ff;
        nxt_eof0 = eof0_ff;
        nxt_eof1 = eof1_ff;
        nxt_disc = disc_ff;
        nxt_out_data = completion_out_data;
        nxt_out_keep = completion_out_keep;
        nxt_out_last = completion_out_last;
        nxt_sb = completion_sideband;
        nxt_out_valid = completion_out_valid && !completion_out_ready;
        take = 1'b0;
        flush = 1'b0;
        pkt_end = 1'b0;
        desc_done = 1'b0;
        if (can_out && buf_if.valid) begin
            take = 1'b1;
            // Drop the Dword into its lane; descriptor bytes get no strobes.
            for (int i = 0; i < LANES; i++) begin
                if (3'(i) == pos_ff) begin
                    nxt_acc_data[32*i +: 32] = e_dw;
                    nxt_acc_be[4*i +: 4] = (st_ff == RCSO_PAY) ? e_be : 4'h0;
                end
            end
            if (e_sop) begin
                nxt_starts = starts_ff + 2'h1;
            end
            case (st_ff)
                RCSO_IDLE: begin
                    nxt_dcnt = 2'h1;
                    nxt_st = RCSO_DESC;
                end
                RCSO_DESC: begin
                    nxt_dcnt = dcnt_ff + 2'h1;
                    if (nxt_dcnt == DESC_DW) begin
                        nxt_st = RCSO_PAY;
                        desc_done = 1'b1;
                    end
                end
                RCSO_PAY: begin
                    nxt_st = RCSO_PAY;
                end
                default: begin
                    nxt_st = RCSO_IDLE;
                end
            endcase
            if (e_eop) begin
                nxt_st = RCSO_IDLE;
                nxt_dcnt = 2'h0;
                nxt_ends = ends_ff + 2'h1;
                nxt_disc = disc_ff | e_disc;
                if (ends_ff == 2'h0) begin
                    nxt_eof0 = pos_ff;
                end else begin
                    nxt_eof1 = pos_ff;
                end
                // A second packet may share the beat only behind an early,
                // clean end; a discontinued packet closes its beat.
                if (STR && pos_ff <= STR_MAX_END && ends_ff == 2'h0 && !e_disc) begin
                    nxt_pos = STR_SECOND_POS;
                end else begin
                    flush = 1'b1;
                    pkt_end = 1'b1;
                end
            end else if (pos_ff == LAST_LANE) begin
                flush = 1'b1;
            end else if (e_aa && desc_done) begin
                // Payload waits for the next beat at the requested lane.
                flush = 1'b1;
            end else begin
                nxt_pos = pos_ff + 3'h1;
            end
        end else if (STR && can_out && ends_ff != 2'h0) begin
            // Nothing ready to straddle in: send the short beat now.
            flush = 1'b1;
            pkt_end = 1'b1;
        end
        if (flush) begin
            nxt_out_valid = 1'b1;
            nxt_out_data = nxt_acc_data;
            if (STR) begin
                nxt_out_keep = '1;
                nxt_out_last = 1'b0;
            end else begin
                nxt_out_keep = pkt_end ? fill_mask(pos_ff) : '1;
                nxt_out_last = pkt_end;
            end
            nxt_sb = '0;
            nxt_sb[SB_BE_LSB +: BE_W] = nxt_acc_be;
            nxt_sb[SB_SOF0] = (nxt_starts != 2'h0);
            nxt_sb[SB_DISC] = nxt_disc;
            if (STR) begin
                nxt_sb[SB_SOF1] = (nxt_starts == 2'h2);
                nxt_sb[SB_EOF0_LSB +: 4] = {nxt_eof0, nxt_ends != 2'h0};
                nxt_sb[SB_EOF1_LSB +: 4] = {nxt_eof1, nxt_ends == 2'h2};
            end
            // Fresh beat: no strobes, flags or ends carried over.
            nxt_acc_be = '0;
            nxt_starts = 2'h0;
            nxt_ends = 2'h0;
            nxt_eof0 = 3'h0;
            nxt_eof1 = 3'h0;
            nxt_disc = 1'b0;
            nxt_pos = (e_aa && desc_done && take && !e_eop) ? (e_off & LAST_LANE) : 3'h0;
        end
    end

    // All gatherer and output state, cleared to an idle stream.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= RCSO_IDLE;
            dcnt_ff <= 2'h0;
            pos_ff <= 3'h0;
            acc_data_ff <= '0;
            acc_be_ff <= '0;
            starts_ff <= 2'h0;
            ends_ff <= 2'h0;
            eof0_ff <= 3'h0;
            eof1_ff <= 3'h0;
            disc_ff <= 1'b0;
            completion_out_data <= '0;
            // A straddled build shows all keep bits set from reset on.
            completion_out_keep <= {LANES{STR}};
            completion_out_last <= 1'b0;
            completion_out_valid <= 1'b0;
            completion_sideband <= '0;
        end else begin
            st_ff <= nxt_st;
            dcnt_ff <= nxt_dcnt;
            pos_ff <= nxt_pos;
            acc_data_ff <= nxt_acc_data;
            acc_be_ff <= nxt_acc_be;
            starts_ff <= nxt_starts;
            ends_ff <= nxt_ends;
            eof0_ff <= nxt_eof0;
            eof1_ff <= nxt_eof1;
            disc_ff <= nxt_disc;
            completion_out_data <= nxt_out_data;
            completion_out_keep <= nxt_out_keep;
            completion_out_last <= nxt_out_last;
            completion_out_valid <= nxt_out_valid;
            completion_sideband <= nxt_sb;
        end
    end

    // ------------------------------------------------------------
    // Checks on the delivered stream.
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic in_pkt_ff;   // An unstraddled packet is open on the output.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            in_pkt_ff <= 1'b0;
        end else if (completion_out_valid && completion_out_ready) begin
            in_pkt_ff <= !completion_out_last;
        end
    end

    a_sof_first_beat: assert property (!STR && completion_out_valid |->
        completion_sideband[SB_SOF0] == !in_pkt_ff) else $error("start flag misplaced");
    a_desc_no_strobe: assert property (!STR && completion_out_valid &&
        completion_sideband[SB_SOF0] |-> completion_sideband[SB_BE_LSB +: 8] == '0)
        else $error("strobes on descriptor");
    a_aa_desc_split: assert property (take && e_aa && desc_done && !e_eop |=>
        completion_out_valid && !completion_out_last && pos_ff == ($past(e_off) & LAST_LANE))
        else $error("aligned payload not in next beat at offset");
    a_keep_nonlast: assert property (completion_out_valid && !completion_out_last |->
        completion_out_keep == '1) else $error("keep gap before last beat");
    a_str_keep_last: assert property (STR |-> completion_out_keep == '1 &&
        !completion_out_last) else $error("straddle keep or last moved");
    a_sof1_consist: assert property (completion_out_valid && completion_sideband[SB_SOF1] |->
        completion_sideband[SB_SOF0] && completion_sideband[SB_EOF0_LSB] &&
        completion_sideband[SB_EOF0_LSB+1 +: 3] <= STR_MAX_END)
        else $error("second start without early first end");
    a_eof1_offset: assert property (completion_out_valid && completion_sideband[SB_EOF1_LSB] |->
        completion_sideband[SB_EOF0_LSB] && completion_sideband[SB_EOF1_LSB+1 +: 3] >= 3'h6 &&
        completion_sideband[SB_EOF0_LSB+1 +: 3] <= STR_MAX_END)
        else $error("second end offset out of range");
    a_stall_hold: assert property (completion_out_valid && !completion_out_ready |=>
        completion_out_valid && $stable(completion_out_data) && $stable(completion_sideband))
        else $error("beat changed under stall");
    a_reset_quiet: assert property (@(posedge ref_clk) disable iff (1'b0)
        !resetn |-> !completion_out_valid) else $error("valid during reset");

    c_two_starts: cover property (completion_out_valid && completion_sideband[SB_SOF1]);
    c_aligned_split: cover property (take && e_aa && desc_done && !e_eop);
    c_user_stall: cover property (completion_out_valid && !completion_out_ready [*3]);

endmodule : rcso_framer

//--- core/rcso_pkg.sv
package rcso_pkg;

    // ------------------------------------------------------------
    // Sideband layout.
    // ------------------------------------------------------------
    localparam int unsigned SB_W = 43;         // Sideband width.
    localparam int unsigned SB_BE_LSB = 0;     // Byte strobes start here.
    localparam int unsigned SB_SOF0 = 32;      // First start flag.
    localparam int unsigned SB_SOF1 = 33;      // Second start flag.
    localparam int unsigned SB_EOF0_LSB = 34;  // First end group, four bits.
    localparam int unsigned SB_EOF1_LSB = 38;  // Second end group, four bits.
    localparam int unsigned SB_DISC = 42;      // Discontinue bit.

    // ------------------------------------------------------------
    // Buffered Dword entry layout.
    // ------------------------------------------------------------
    localparam int unsigned ENT_W = 43;        // Entry width.
    localparam int unsigned ENT_DW_LSB = 0;    // Dword data.
    localparam int unsigned ENT_BE_LSB = 32;   // Four byte strobes.
    localparam int unsigned ENT_SOP = 36;      // First Dword of packet.
    localparam int unsigned ENT_EOP = 37;      // Last Dword of packet.
    localparam int unsigned ENT_DISC = 38;     // Payload error seen.
    localparam int unsigned ENT_AA = 39;       // Address-aligned packet.
    localparam int unsigned ENT_OFF_LSB = 40;  // Three-bit alignment offset.

    // ------------------------------------------------------------
    // Framing constants.
    // ------------------------------------------------------------
    localparam logic [1:0] DESC_DW = 2'h3;          // Descriptor Dwords.
    localparam logic [2:0] STR_MAX_END = 3'h3;      // Latest end before a straddle.
    localparam logic [2:0] STR_SECOND_POS = 3'h4;   // Second packet Dword lane.

    // Packet progress through the gatherer.
    typedef enum logic [1:0] {
        RCSO_IDLE = 2'b00,
        RCSO_DESC = 2'b01,
        RCSO_PAY  = 2'b10
    } rcso_state_t;

endpackage : rcso_pkg

//--- core/rcso_stream_if.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Valid and ready word carrier between the framer and its buffer.
// ------------------------------------------------------------
interface rcso_stream_if #(parameter int unsigned W = 8);
    logic valid;          // Word offered.
    logic ready;          // Word taken.
    logic [W-1:0] data;   // Word itself.
    modport sink (input valid, input data, output ready);
    modport source (output valid, output data, input ready);
endinterface : rcso_stream_if
